// ### verilog/position_port_pkg.sv
/*
  shared constants of the tracking position counter and its output port:
  widths, resolution codes, reset values and timing counts.
  assumes a 40 MHz core clock; all times are turned into cycle counts here.
*/
package position_port_pkg;

  // word and byte widths of the position bus
  localparam int          DATA_W           = 16;
  localparam int          BYTE_W           = 8;

  // resolution select codes on the two resolution pins
  localparam logic [1:0]  RES_CODE_10      = 2'h0;
  localparam logic [1:0]  RES_CODE_12      = 2'h1;
  localparam logic [1:0]  RES_CODE_14      = 2'h2;
  localparam logic [1:0]  RES_CODE_16      = 2'h3;

  // unused low-order bits below the lsb for each resolution
  localparam logic [3:0]  LSB_SHIFT_10     = 4'h6;
  localparam logic [3:0]  LSB_SHIFT_12     = 4'h4;
  localparam logic [3:0]  LSB_SHIFT_14     = 4'h2;
  localparam logic [3:0]  LSB_SHIFT_16     = 4'h0;

  // one lsb at full width and the all-ones word
  localparam logic [15:0] WORD_ONE         = 16'h0001;
  localparam logic [15:0] WORD_ONES        = 16'hFFFF;
  localparam logic [15:0] WORD_ZERO        = 16'h0000;

  // reset values
  localparam logic [15:0] COUNT_RESET      = 16'h0000;
  localparam logic        SENSE_RESET      = 1'b1;

  // clock and timing figures
  localparam int          CLK_PERIOD_NS    = 25;
  localparam int          BUSY_NS          = 100;
  localparam int          FREEZE_VALID_NS  = 600;
  // least time: round up
  localparam int          BUSY_CYCLES      = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time: round down
  localparam int          FREEZE_VALID_CYC = FREEZE_VALID_NS / CLK_PERIOD_NS;
  localparam int          BUSY_CNT_W       = 8;

endpackage : position_port_pkg

// ### verilog/busy_pulse_gen.sv
/*
  busy pulse generator: a trigger starts or restarts a busy pulse of a fixed
  number of cycles and a one-cycle done strobe marks its end.
  assumes triggers synchronous to the core clock.
*/
`timescale 1ns/1ps
module busy_pulse_gen #(
  parameter int PULSE_CYCLES = position_port_pkg::BUSY_CYCLES,
  parameter int CNT_W        = position_port_pkg::BUSY_CNT_W
) (
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  // trigger in, pulse and end strobe out
  input  wire logic i_trigger,
  output logic      o_busy,
  output logic      o_done
);

  logic [CNT_W-1:0] cnt_reg;
  logic             busy_reg;
  logic             done_reg;

  // pulse width counter, retriggerable
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      cnt_reg  <= '0;
      busy_reg <= 1'b0;
    end else if (i_trigger) begin
      cnt_reg  <= CNT_W'(PULSE_CYCLES - 1);
      busy_reg <= 1'b1;
    end else if (cnt_reg != '0) begin
      cnt_reg  <= cnt_reg - CNT_W'(1);
    end else begin
      busy_reg <= 1'b0;
    end
  end

  // end strobe in the cycle after the last busy cycle
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= busy_reg && (cnt_reg == '0) && !i_trigger;
    end
  end

  assign o_busy = busy_reg;
  assign o_done = done_reg;

endmodule : busy_pulse_gen

// ### verilog/tracking_position_output_port.sv
/*
  digital side of a tracking position converter: resolution-selectable
  up/down counter, output latches with freeze, byte-multiplexed position bus,
  busy pulse per lsb step, revolution wrap pulse and latched rotation sense.
  assumes one-cycle lsb step strobes from the tracking loop, synchronous to
  i_core_clk; the bus wire level is resolved outside from the enables.
*/
// Functional notes
// (R1) enable high floats bus, low drives latch
// (R2) byte choice high: msb byte on first pins
// (R3) freeze low holds output latches
// (R4) preset dir low: all pins are inputs
// (R5) busy high while position data changes; here the latch and bus update 1 and 2 cycles after busy falls
// (R6) wrap pulse on all-ones/all-zeros rollover
// (R7) rotation sense valid before any wrap pulse
// (R8) sense latched, changes only on reversal
// (R9) wrap and sense ignore the freeze input
// (R10) resolution pins pick 10/12/14/16 bits
// (R11) count one lsb per lsb input step
// (R12) one busy pulse per lsb step
// (R13) host changes resolution only while idle
// (R14) position is unsigned natural binary
// (R15) latched data valid 600 ns after freeze
// (R16) freeze release makes refreshing busy pulse
// (R17) lsb byte always on upper pins
// (R18) unused low-order lines driven low
// (R19) counter wraps at selected resolution
`timescale 1ns/1ps
module tracking_position_output_port #(
  parameter int BUSY_CYCLES = position_port_pkg::BUSY_CYCLES
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset,
  // lsb steps from the tracking loop
  input  wire logic        i_step_up,
  input  wire logic        i_step_down,
  // control pins
  input  wire logic [1:0]  i_resolution_pins,
  input  wire logic        i_latch_freeze_n,
  input  wire logic        i_output_enable_n,
  input  wire logic        i_byte_half_choice,
  input  wire logic        i_counter_preset_dir,
  // position data pins, split three ways
  input  wire logic [15:0] i_position_data_pins,
  output logic      [15:0] o_position_data_pins,
  output logic      [15:0] o_position_data_oe,
  // status outputs
  output logic             o_busy,
  output logic             o_wrap_pulse,
  output logic             o_rotation_sense
);

  logic [3:0]  lsb_shift;
  logic [15:0] step_val;
  logic [15:0] res_mask;
  logic        step_up_ok;
  logic        step_dn_ok;
  logic        preset_change;
  logic        freeze_release;
  logic        busy_trigger;
  logic        busy_done;
  logic [15:0] count_reg;
  logic [15:0] latch_reg;
  logic        sense_reg;
  logic        wrap_pend_reg;
  logic        wrap_reg;
  logic        freeze_n_reg;
  logic [15:0] data_reg;
  logic [15:0] oe_reg;

  // resolution decode into lsb position and active-bit mask
  always_comb begin
    case (i_resolution_pins)
      position_port_pkg::RES_CODE_10: lsb_shift = position_port_pkg::LSB_SHIFT_10; // R10
      position_port_pkg::RES_CODE_12: lsb_shift = position_port_pkg::LSB_SHIFT_12;
      position_port_pkg::RES_CODE_14: lsb_shift = position_port_pkg::LSB_SHIFT_14;
      position_port_pkg::RES_CODE_16: lsb_shift = position_port_pkg::LSB_SHIFT_16;
      default:                        lsb_shift = position_port_pkg::LSB_SHIFT_16;
    endcase
  end

  assign step_val = position_port_pkg::WORD_ONE << lsb_shift;
  assign res_mask = position_port_pkg::WORD_ONES << lsb_shift; // R18

  // a step counts only when exactly one direction is strobed and pins drive
  assign step_up_ok     = i_step_up && !i_step_down && i_counter_preset_dir;
  assign step_dn_ok     = i_step_down && !i_step_up && i_counter_preset_dir;
  assign preset_change  = !i_counter_preset_dir
                          && ((i_position_data_pins & res_mask) != count_reg);
  assign freeze_release = i_latch_freeze_n && !freeze_n_reg;
  assign busy_trigger   = step_up_ok || step_dn_ok || preset_change || freeze_release;

  // up/down position counter, left justified so it wraps at 2^resolution
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      count_reg <= position_port_pkg::COUNT_RESET;
    end else if (!i_counter_preset_dir) begin
      count_reg <= i_position_data_pins & res_mask; // R4
    end else if (step_up_ok) begin
      count_reg <= (count_reg + step_val) & res_mask; // R11 R14 R19
    end else if (step_dn_ok) begin
      count_reg <= (count_reg - step_val) & res_mask; // R11 R19
    end else begin
      count_reg <= count_reg & res_mask; // R18
    end
  end

  // rotation sense follows only real steps; freeze plays no part
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      sense_reg <= position_port_pkg::SENSE_RESET;
    end else if (step_up_ok) begin
      sense_reg <= 1'b1; // R8 R9
    end else if (step_dn_ok) begin
      sense_reg <= 1'b0; // R8 R9
    end
  end

  // wrap pulse one cycle after the rollover, so sense has already settled
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      wrap_pend_reg <= 1'b0;
      wrap_reg      <= 1'b0;
    end else begin
      wrap_pend_reg <= (step_up_ok && (count_reg == res_mask))
                       || (step_dn_ok && (count_reg == position_port_pkg::WORD_ZERO)); // R6 R19
      wrap_reg      <= wrap_pend_reg; // R7 R9
    end
  end

  // freeze input history for the release edge
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      freeze_n_reg <= 1'b1;
    end else begin
      freeze_n_reg <= i_latch_freeze_n;
    end
  end

  // busy pulse per step, per preset change and per freeze release
  busy_pulse_gen #(
    .PULSE_CYCLES (BUSY_CYCLES),
    .CNT_W        (position_port_pkg::BUSY_CNT_W)
  ) u_busy (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_trigger  (busy_trigger), // R5 R12 R16
    .o_busy     (o_busy),
    .o_done     (busy_done)
  );

  // output latches refresh at the end of busy unless frozen
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      latch_reg <= position_port_pkg::COUNT_RESET;
    end else if (busy_done && i_latch_freeze_n) begin
      latch_reg <= count_reg; // R3 R15 R16
    end
  end

  // byte multiplexer and enables, registered
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      data_reg <= position_port_pkg::WORD_ZERO;
      oe_reg   <= position_port_pkg::WORD_ZERO;
    end else begin
      data_reg[7:0] <= latch_reg[7:0]; // R17
      if (i_byte_half_choice) begin
        data_reg[15:8] <= latch_reg[15:8]; // R2
      end else begin
        data_reg[15:8] <= latch_reg[7:0]; // R2
      end
      oe_reg <= {position_port_pkg::DATA_W{!i_output_enable_n && i_counter_preset_dir}}; // R1 R4
    end
  end

  assign o_position_data_pins = data_reg;
  assign o_position_data_oe   = oe_reg;
  assign o_wrap_pulse         = wrap_reg;
  assign o_rotation_sense     = sense_reg;

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_release;
    !i_latch_freeze_n ##1 i_latch_freeze_n;
  endsequence

  sequence s_up_wrap;
    step_up_ok && (count_reg == res_mask);
  endsequence

  chk_oe_enable: assert property ( // R1
    !i_reset |=> (o_position_data_oe
                  == {16{$past(!i_output_enable_n && i_counter_preset_dir)}}))
    else $error("bus enable does not follow enable and preset direction");

  chk_first_byte: assert property ( // R2
    !i_reset |=> (o_position_data_pins[15:8]
         == ($past(i_byte_half_choice) ? $past(latch_reg[15:8]) : $past(latch_reg[7:0]))))
    else $error("wrong byte on first data pins");

  chk_lsb_upper: assert property ( // R17
    !i_reset |=> (o_position_data_pins[7:0] == $past(latch_reg[7:0])))
    else $error("lsb byte missing on upper data pins");

  chk_freeze_hold: assert property ( // R3
    !i_reset && !i_latch_freeze_n |=> $stable(latch_reg))
    else $error("latch changed while frozen");

  chk_freeze_valid: assert property ( // R15
    $fell(i_latch_freeze_n) ##1 !i_latch_freeze_n [*7] |-> $stable(latch_reg))
    else $error("latched data unstable after freeze");

  chk_busy_step: assert property ( // R12
    !i_reset && (step_up_ok || step_dn_ok) |=> o_busy [*4])
    else $error("no busy pulse for a step");

  chk_release_busy: assert property ( // R16
    s_release |=> o_busy ##[1:8] (latch_reg == $past(count_reg)))
    else $error("freeze release did not refresh latch");

  chk_wrap_delay: assert property ( // R6
    s_up_wrap |=> !o_wrap_pulse ##1 o_wrap_pulse)
    else $error("wrap pulse missing after rollover");

  chk_sense_ahead: assert property ( // R7
    $rose(o_wrap_pulse) |-> $stable(o_rotation_sense))
    else $error("sense changed together with wrap pulse");

  chk_sense_reverse: assert property ( // R8
    $changed(o_rotation_sense) |-> $past(step_up_ok || step_dn_ok || i_reset))
    else $error("sense changed without a step");

  chk_low_zero: assert property ( // R18
    !i_reset |=> ((count_reg & ~$past(res_mask)) == position_port_pkg::WORD_ZERO))
    else $error("unused low-order bits not low");

endmodule : tracking_position_output_port

// ### tb/host_bus_model.sv
/*
  host side of the position bus: resolves the wire level and keeps the last
  word seen while the bus was driven and busy was low.
  assumes one core clock shared with the device.
*/
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input  wire logic        i_core_clk,
  // device side of the bus
  input  wire logic [15:0] i_data,
  input  wire logic [15:0] i_oe,
  input  wire logic        i_busy,
  // host drive request
  input  wire logic        i_host_drive,
  input  wire logic [15:0] i_host_val,
  // resolved wire and last valid read
  output logic      [15:0] o_wire,
  output logic      [15:0] o_seen
);
  logic [15:0] float_reg = 16'h0000;
  // resolve the wire; a floating bus shows a pattern that flips every cycle
  always_comb begin
    if (i_oe != 16'h0000) o_wire = i_data;
    else if (i_host_drive) o_wire = i_host_val;
    else o_wire = float_reg;
  end
  // flip pattern for the floating bus
  always @(posedge i_core_clk) float_reg <= ~float_reg;
  // take a word only while enabled and not busy
  always_ff @(posedge i_core_clk) begin
    if (i_oe == 16'hFFFF && !i_busy) o_seen <= o_wire;
  end
endmodule : host_bus_model

// ### tb/tb.sv
/*
  self-checking bench of the position port: steps, wraps, freeze, byte
  choice, enable and preset, against an integer model of the counter.
  assumes the host model resolves the bus wire.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic        clk = 0, rst = 1, up = 0, dn = 0, frz_n = 1, oe_n = 0;
  logic        byte_hi = 1, dir = 1, host_drv = 0, exp_sense = 1;
  logic        wrap_dir_q[$];
  logic [1:0]  res = 2'h3;
  logic [15:0] host_val = 16'h0000, pins, dout, oe, seen, held;
  logic        busy, wrap, sense;
  int          failures = 0, comparisons = 0, wraps = 0, exp_wraps = 0;
  int          cnt = 0, n = 16, k, seed = 32'h3994;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  tracking_position_output_port #(.BUSY_CYCLES(position_port_pkg::BUSY_CYCLES)) DUT (
    .i_core_clk(clk), .i_reset(rst), .i_step_up(up), .i_step_down(dn),
    .i_resolution_pins(res), .i_latch_freeze_n(frz_n), .i_output_enable_n(oe_n),
    .i_byte_half_choice(byte_hi), .i_counter_preset_dir(dir),
    .i_position_data_pins(pins), .o_position_data_pins(dout), .o_position_data_oe(oe),
    .o_busy(busy), .o_wrap_pulse(wrap), .o_rotation_sense(sense));
  host_bus_model HOST (.i_core_clk(clk), .i_data(dout), .i_oe(oe), .i_busy(busy),
    .i_host_drive(host_drv), .i_host_val(host_val), .o_wire(pins), .o_seen(seen));
  // count wraps; direction must already be valid on each one
  always @(posedge clk) begin
    if (wrap === 1'b1) begin
      wraps++;
      if (wrap_dir_q.size() != 0) exp_sense = wrap_dir_q.pop_front();
      `CHK(sense, exp_sense)
    end
  end
  // expected bus word: left justified count, low byte always on the upper pins
  function automatic logic [15:0] ew();
    logic [15:0] w;
    w = 16'(cnt) << (16 - n);
    return {byte_hi ? w[15:8] : w[7:0], w[7:0]};
  endfunction : ew
  task check_out();
    `CHK(seen, ew())
  endtask : check_out
  // one lsb step up or down, then settle
  task step(input logic u);
    @(posedge clk);
    up <= u;
    dn <= !u;
    @(posedge clk);
    up <= 0;
    dn <= 0;
    #1;
    `CHK(busy, 1'b1)
    if ((u && cnt == (1 << n) - 1) || (!u && cnt == 0)) begin
      exp_wraps++;
      wrap_dir_q.push_back(u);
    end
    cnt = u ? (cnt + 1) % (1 << n) : (cnt + (1 << n) - 1) % (1 << n);
    repeat (12) @(posedge clk);
    `CHK(wraps, exp_wraps)
    `CHK(sense, u)
  endtask : step
  task end_sim();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // watchdog
  initial begin
    #(25ns * 5000);
    failures++;
    end_sim();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    `CHK(dout, 16'h0000)
    `CHK(sense, 1'b1)
    // every resolution: wrap both ways, random run up, one reversal
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      res <= r[1:0];
      rst <= 1;
      @(posedge clk);
      rst <= 0;
      n = 10 + 2 * r;
      cnt = 0;
      step(0);
      step(1);
      k = ($random(seed) & 7) + 1;
      repeat (k) step(1);
      step(0);
      check_out();
    end
    // low byte on the first pins too
    byte_hi <= 0;
    repeat (3) @(posedge clk);
    check_out();
    byte_hi <= 1;
    // enable high floats the bus
    oe_n <= 1;
    repeat (3) @(posedge clk);
    `CHK(oe, 16'h0000)
    oe_n <= 0;
    repeat (3) @(posedge clk);
    `CHK(oe, 16'hFFFF)
    // freeze holds the latch while steps and sense go on
    frz_n <= 0;
    repeat (24) @(posedge clk);
    held = ew();
    step(1);
    step(0);
    step(0);
    `CHK(seen, held)
    frz_n <= 1;
    repeat (14) @(posedge clk);
    check_out();
    // preset from the pins while they are inputs
    dir <= 0;
    host_drv <= 1;
    host_val <= 16'($random(seed));
    repeat (10) @(posedge clk);
    `CHK(oe, 16'h0000)
    cnt = int'(host_val >> (16 - n));
    dir <= 1;
    host_drv <= 0;
    repeat (14) @(posedge clk);
    check_out();
    // both strobes at once are no step: no busy, no count change
    up <= 1;
    dn <= 1;
    @(posedge clk);
    up <= 0;
    dn <= 0;
    #1;
    `CHK(busy, 1'b0)
    repeat (14) @(posedge clk);
    check_out();
    end_sim();
  end
endmodule : tb
